// >>> logic/trigger_sequencer_map.vh
`ifndef TRIGGER_SEQUENCER_MAP_VH
`define TRIGGER_SEQUENCER_MAP_VH

// ----------------------------------------------------------------------------
// Register byte addresses.
// ----------------------------------------------------------------------------
`define TSQ_ADDR_CONTROL      8'h00
`define TSQ_ADDR_TIMER0_LIM   8'h04
`define TSQ_ADDR_TIMER1_LIM   8'h08
`define TSQ_ADDR_STEP_DLY     8'h0C
`define TSQ_ADDR_COUNTER0_LIM 8'h10
`define TSQ_ADDR_COUNTER1_LIM 8'h14
`define TSQ_ADDR_HOLD         8'h18
`define TSQ_ADDR_ADJUST       8'h1C
`define TSQ_ADDR_LITERAL      8'h20
`define TSQ_ADDR_QUEUE_PTR    8'h24
`define TSQ_ADDR_ADC_CHSEL    8'h28
`define TSQ_ADDR_QUEUE_BASE   8'h40

// ----------------------------------------------------------------------------
// Field positions and widths.
// ----------------------------------------------------------------------------
`define TSQ_CTRL_ENABLE_BIT   0
`define TSQ_CTRL_START_BIT    1
`define TSQ_CTRL_SDEN_BIT     2
`define TSQ_CTRL_BUSY_BIT     3
`define TSQ_QPTR_WIDTH        5
`define TSQ_QUEUE_REGS        8

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define TSQ_RESET_VALUE       16'h0000
`define TSQ_QPTR_RESET        5'h00

// ----------------------------------------------------------------------------
// Command codes, options and AXI responses.
// ----------------------------------------------------------------------------
`define TSQ_CMD_CONTROL       4'h0
`define TSQ_CMD_ADDCOPY       4'h1
`define TSQ_OPT_SD_OFF        4'h2
`define TSQ_OPT_SD_ON         4'h6
`define TSQ_OPT_TIMER0        4'h8
`define TSQ_OPT_TIMER1        4'h9
`define TSQ_OPT_LIT_CHSEL     4'hE
`define TSQ_RESP_OKAY         2'h0
`define TSQ_RESP_SLVERR       2'h2

`endif

// >>> logic/trigger_sequencer_param_regs.v
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "trigger_sequencer_map.vh"

module trigger_sequencer_param_regs (
    input  wire        clk_sys_i,      // System clock, 20 MHz.
    input  wire        srst_i,         // Synchronous reset, active high.
    input  wire        ce_i,           // Clock enable; low freezes all state.
    input  wire [7:0]  s_axi_awaddr,   // Write address.
    input  wire        s_axi_awvalid,  // Write address valid.
    output reg         s_axi_awready,  // Write address ready.
    input  wire [31:0] s_axi_wdata,    // Write data.
    input  wire [3:0]  s_axi_wstrb,    // Write byte strobes.
    input  wire        s_axi_wvalid,   // Write data valid.
    output reg         s_axi_wready,   // Write data ready.
    output reg  [1:0]  s_axi_bresp,    // Write response.
    output reg         s_axi_bvalid,   // Write response valid.
    input  wire        s_axi_bready,   // Write response ready.
    input  wire [7:0]  s_axi_araddr,   // Read address.
    input  wire        s_axi_arvalid,  // Read address valid.
    output reg         s_axi_arready,  // Read address ready.
    output reg  [31:0] s_axi_rdata,    // Read data.
    output reg  [1:0]  s_axi_rresp,    // Read response.
    output reg         s_axi_rvalid,   // Read data valid.
    input  wire        s_axi_rready,   // Read data ready.
    output reg  [15:0] adc_chsel_o,    // ADC channel select value.
    output reg         adc_chsel_wr_o  // One-cycle strobe when channel select is written.
);

    // ------------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------------
    reg  [15:0] timer0_limit_r;      // Timer 0 limit.
    reg  [15:0] timer1_limit_r;      // Timer 1 limit.
    reg  [15:0] step_delay_limit_r;  // Step delay limit.
    reg  [15:0] counter0_limit_r;    // Counter 0 limit.
    reg  [15:0] counter1_limit_r;    // Counter 1 limit.
    reg  [15:0] hold_value_r;        // Copy source.
    reg  [15:0] adjust_value_r;      // Add source.
    reg  [15:0] literal_value_r;     // Literal for channel select.
    reg  [4:0]  queue_pointer_r;     // Current step index.
    reg  [15:0] step_queue_r [0:7];  // Sixteen command bytes, no reset.
    reg         seq_enable_r;        // Sequencer enable.
    reg         seq_start_r;         // Sequencer start.
    reg         sd_enable_r;         // Step delay timer enable.
    reg  [15:0] delay_cnt_r;         // Step delay counter.
    reg  [15:0] timer_cnt_r;         // Shared timer for timer waits.
    reg         timer_wait_r;        // A timer wait is under way.
    reg  [15:0] counter0_r;          // Loop counter 0.
    reg  [15:0] counter1_r;          // Loop counter 1.

    // Write channel staging.
    reg         aw_held_r;           // Write address captured.
    reg  [7:0]  aw_addr_r;           // Captured write address.
    reg         w_held_r;            // Write data captured.
    reg  [31:0] w_data_r;            // Captured write data.
    reg  [3:0]  w_strb_r;            // Captured strobes.

    // ------------------------------------------------------------------------
    // Decode of the current step.
    // ------------------------------------------------------------------------
    // Control stays writable while locked, so software can stop the run.
    // The lock spans parameter, pointer and queue registers.
    wire        locked  = seq_enable_r & seq_start_r;
    wire        running = locked;
    // Pointer bits 3:1 pick the word, the low bit the byte; bit 4 is ignored.
    wire [15:0] cur_word = step_queue_r[queue_pointer_r[3:1]];
    wire [7:0]  cur_step = queue_pointer_r[0] ? cur_word[15:8]
                                              : cur_word[7:0];
    wire [3:0]  cmd = cur_step[7:4];
    wire [3:0]  opt = cur_step[3:0];
    wire        is_t0 = (cmd == `TSQ_CMD_CONTROL) && (opt == `TSQ_OPT_TIMER0);
    wire        is_t1 = (cmd == `TSQ_CMD_CONTROL) && (opt == `TSQ_OPT_TIMER1);
    // Timer 1 limit applies unless the step names timer 0.
    wire [15:0] t_lim = is_t0 ? timer0_limit_r : timer1_limit_r;
    // A timer wait ends when the shared count meets the named limit.
    wire        timer_done = timer_wait_r && (timer_cnt_r == t_lim);
    // With the delay on, a step without a timer wait lasts the limit plus one clock.
    // With it off, a step without a timer wait completes in its first clock.
    wire        delay_done = !sd_enable_r || (delay_cnt_r == step_delay_limit_r);
    wire        step_done = running && delay_done &&
                            (!(is_t0 || is_t1) || timer_done);
    // A write lands once address and data are held and b is free.
    wire        do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    wire        wr_ok = do_write && !locked;
    // Strobes widen to a bit mask; lanes 0 and 1 reach storage.
    wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                         {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [15:0] wnew = w_data_r[15:0];
    wire [15:0] wm16 = wmask[15:0];

    // Merges a masked write into a 16-bit register.
    function [15:0] merge16;
        input [15:0] old_v;
        input [15:0] new_v;
        input [15:0] m;
        begin
            merge16 = (old_v & ~m) | (new_v & m);
        end
    endfunction

    // Copy or add source for the step, per option.
    wire [15:0] src_val = opt[3] ? hold_value_r : adjust_value_r;
    // Reserved add or copy options act as no-ops.
    wire        is_ac   = step_done && (cmd == `TSQ_CMD_ADDCOPY) &&
                          (opt[2:0] <= 3'h5);

    // Returns the new target value of an add or copy.
    function [15:0] apply;
        input [15:0] old_v;
        begin
            apply = opt[3] ? src_val : old_v + src_val;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Parameter registers: software writes when unlocked, steps when running.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            // Reset clears parameters and stops the sequencer.
            timer0_limit_r     <= `TSQ_RESET_VALUE;
            timer1_limit_r     <= `TSQ_RESET_VALUE;
            step_delay_limit_r <= `TSQ_RESET_VALUE;
            counter0_limit_r   <= `TSQ_RESET_VALUE;
            counter1_limit_r   <= `TSQ_RESET_VALUE;
            hold_value_r       <= `TSQ_RESET_VALUE;
            adjust_value_r     <= `TSQ_RESET_VALUE;
            literal_value_r    <= `TSQ_RESET_VALUE;
            seq_enable_r       <= 1'b0;
            seq_start_r        <= 1'b0;
        end else if (ce_i) begin
            // Control is always writable so software can stop the sequencer.
            if (do_write && aw_addr_r == `TSQ_ADDR_CONTROL && w_strb_r[0]) begin
                seq_enable_r <= w_data_r[`TSQ_CTRL_ENABLE_BIT];
                seq_start_r  <= w_data_r[`TSQ_CTRL_START_BIT];
            end
            if (wr_ok) begin
                // Software path, only when not locked.
                case (aw_addr_r)
                    `TSQ_ADDR_TIMER0_LIM:   timer0_limit_r <= merge16(timer0_limit_r, wnew, wm16);
                    `TSQ_ADDR_TIMER1_LIM:   timer1_limit_r <= merge16(timer1_limit_r, wnew, wm16);
                    `TSQ_ADDR_STEP_DLY:
                        step_delay_limit_r <= merge16(step_delay_limit_r, wnew, wm16);
                    `TSQ_ADDR_COUNTER0_LIM:
                        counter0_limit_r <= merge16(counter0_limit_r, wnew, wm16);
                    `TSQ_ADDR_COUNTER1_LIM:
                        counter1_limit_r <= merge16(counter1_limit_r, wnew, wm16);
                    `TSQ_ADDR_HOLD:         hold_value_r <= merge16(hold_value_r, wnew, wm16);
                    `TSQ_ADDR_ADJUST:       adjust_value_r <= merge16(adjust_value_r, wnew, wm16);
                    `TSQ_ADDR_LITERAL:      literal_value_r <= merge16(literal_value_r, wnew, wm16);
                    default: begin
                        // Other addresses are handled elsewhere.
                    end
                endcase
            end else if (is_ac) begin
                // Step path: option low bits pick the target.
                case (opt[2:0])
                    3'h0:    counter0_limit_r   <= apply(counter0_limit_r);
                    3'h1:    counter1_limit_r   <= apply(counter1_limit_r);
                    3'h2:    timer0_limit_r     <= apply(timer0_limit_r);
                    3'h3:    timer1_limit_r     <= apply(timer1_limit_r);
                    3'h4:    step_delay_limit_r <= apply(step_delay_limit_r);
                    // Option five: the literal.
                    default: literal_value_r    <= apply(literal_value_r);
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Step queue: no reset term, so contents survive every reset.
    // ------------------------------------------------------------------------
    // Each word has its own process; initial gives the power-up value.
    // No reset term reaches these flip-flops.
    genvar gi;
    generate
        for (gi = 0; gi < `TSQ_QUEUE_REGS; gi = gi + 1) begin : g_queue
            initial step_queue_r[gi] = `TSQ_RESET_VALUE;
            always @(posedge clk_sys_i) begin
                if (ce_i && wr_ok &&
                    aw_addr_r == (`TSQ_ADDR_QUEUE_BASE + gi * 4)) begin
                    step_queue_r[gi] <= merge16(step_queue_r[gi], wnew, wm16);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Step engine: pointer, delay, timer, jump counters, channel select.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            // Reset returns the pointer to the first step.
            queue_pointer_r <= `TSQ_QPTR_RESET;
            sd_enable_r     <= 1'b0;
            delay_cnt_r     <= `TSQ_RESET_VALUE;
            timer_cnt_r     <= `TSQ_RESET_VALUE;
            timer_wait_r    <= 1'b0;
            counter0_r      <= `TSQ_RESET_VALUE;
            counter1_r      <= `TSQ_RESET_VALUE;
            adc_chsel_o     <= `TSQ_RESET_VALUE;
            adc_chsel_wr_o  <= 1'b0;
        end else if (ce_i) begin
            adc_chsel_wr_o <= 1'b0;
            // While stopped, the delay and timer counts clear and the pointer may load; loop counters keep their values.
            if (!running) begin
                delay_cnt_r  <= `TSQ_RESET_VALUE;
                timer_wait_r <= 1'b0;
                timer_cnt_r  <= `TSQ_RESET_VALUE;
                if (wr_ok && aw_addr_r == `TSQ_ADDR_QUEUE_PTR && w_strb_r[0])
                    queue_pointer_r <= w_data_r[4:0];
            end else if (!step_done) begin
                // Count the delay and the timer until the step completes.
                if (sd_enable_r && delay_cnt_r != step_delay_limit_r)
                    delay_cnt_r <= delay_cnt_r + 16'h0001;
                // The first clock of a wait clears the timer.
                if (is_t0 || is_t1) begin
                    if (!timer_wait_r) begin
                        timer_wait_r <= 1'b1;
                        timer_cnt_r  <= `TSQ_RESET_VALUE;
                    end else if (timer_cnt_r != t_lim) begin
                        timer_cnt_r <= timer_cnt_r + 16'h0001;
                    end
                end
            end else begin
                delay_cnt_r     <= `TSQ_RESET_VALUE;
                timer_wait_r    <= 1'b0;
                timer_cnt_r     <= `TSQ_RESET_VALUE;
                queue_pointer_r <= queue_pointer_r + 5'h01;
                case (cmd)
                    `TSQ_CMD_CONTROL: begin
                        if (opt == `TSQ_OPT_SD_OFF)
                            sd_enable_r <= 1'b0;
                        else if (opt == `TSQ_OPT_SD_ON)
                            sd_enable_r <= 1'b1;
                        else if (opt == `TSQ_OPT_LIT_CHSEL) begin
                            adc_chsel_o    <= literal_value_r;
                            adc_chsel_wr_o <= 1'b1;
                        end
                    end
                    // Plain jump to the command's low bit and option.
                    4'hA, 4'hB: queue_pointer_r <= {cmd[0], opt};
                    // Counted jump: loop until the limit, then fall through.
                    // The counter clears for the next loop.
                    4'hC, 4'hD: begin
                        if (counter0_r == counter0_limit_r) begin
                            counter0_r <= `TSQ_RESET_VALUE;
                        end else begin
                            counter0_r      <= counter0_r + 16'h0001;
                            queue_pointer_r <= {cmd[0], opt};
                        end
                    end
                    // Same for the second loop counter.
                    4'hE, 4'hF: begin
                        if (counter1_r == counter1_limit_r) begin
                            counter1_r <= `TSQ_RESET_VALUE;
                        end else begin
                            counter1_r      <= counter1_r + 16'h0001;
                            queue_pointer_r <= {cmd[0], opt};
                        end
                    end
                    default: begin
                        // Other commands act outside this block or as no-ops.
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write path.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            aw_held_r     <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_held_r      <= 1'b0;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TSQ_RESP_OKAY;
        end else if (ce_i) begin
            // Readies pulse one clock, only while the slot is empty.
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            // The response follows both halves of the write.
            if (do_write) begin
                // Locked writes get the same response as unlocked ones; value is kept unless the target is control.
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r[7:2] <= 6'h0A ||
                                 (aw_addr_r >= `TSQ_ADDR_QUEUE_BASE &&
                                  aw_addr_r < 8'h60)) ? `TSQ_RESP_OKAY : `TSQ_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read path; mapped reads return current contents, locked or not; other addresses give zero and SLVERR.
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TSQ_RESP_OKAY;
        end else if (ce_i) begin
            // An address is taken only while no read data waits.
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `TSQ_RESP_OKAY;
                case (s_axi_araddr)
                    `TSQ_ADDR_CONTROL:
                        s_axi_rdata <= {28'h0000000, locked, sd_enable_r,
                                        seq_start_r, seq_enable_r};
                    `TSQ_ADDR_TIMER0_LIM:   s_axi_rdata <= {16'h0000, timer0_limit_r};
                    `TSQ_ADDR_TIMER1_LIM:   s_axi_rdata <= {16'h0000, timer1_limit_r};
                    `TSQ_ADDR_STEP_DLY:     s_axi_rdata <= {16'h0000, step_delay_limit_r};
                    `TSQ_ADDR_COUNTER0_LIM: s_axi_rdata <= {16'h0000, counter0_limit_r};
                    `TSQ_ADDR_COUNTER1_LIM: s_axi_rdata <= {16'h0000, counter1_limit_r};
                    `TSQ_ADDR_HOLD:         s_axi_rdata <= {16'h0000, hold_value_r};
                    `TSQ_ADDR_ADJUST:       s_axi_rdata <= {16'h0000, adjust_value_r};
                    `TSQ_ADDR_LITERAL:      s_axi_rdata <= {16'h0000, literal_value_r};
                    `TSQ_ADDR_QUEUE_PTR:    s_axi_rdata <= {27'h0000000, queue_pointer_r};
                    `TSQ_ADDR_ADC_CHSEL:    s_axi_rdata <= {16'h0000, adc_chsel_o};
                    default: begin
                        // Eight queue words at consecutive word addresses.
                        if (s_axi_araddr >= `TSQ_ADDR_QUEUE_BASE && s_axi_araddr < 8'h60) begin
                            s_axi_rdata <= {16'h0000, step_queue_r[s_axi_araddr[4:2]]};
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= `TSQ_RESP_SLVERR;
                        end
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// >>> bench/param_regs_checker_properties.sv
`timescale 1ns/1ps
// ----
// Port checker for the parameter register bank.
// ----
module param_regs_checker (
    input wire        clk_sys_i,
    input wire        srst_i,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        adc_chsel_wr_o
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    aw_ready_cause_a: assert property (s_axi_awready |-> $past(s_axi_awvalid))
        else $error("awready without awvalid.");
    w_ready_cause_a: assert property (s_axi_wready |-> $past(s_axi_wvalid))
        else $error("wready without wvalid.");
    ar_ready_cause_a: assert property (s_axi_arready |-> $past(s_axi_arvalid))
        else $error("arready without arvalid.");
    aw_ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle.");
    read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late.");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped.");
    write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped.");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero.");
    err_data_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data.");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (adc_chsel_wr_o);
endmodule
bind trigger_sequencer_param_regs param_regs_checker u_chk (.*);

// >>> bench/trigger_sequencer_param_regs_test.sv
`timescale 1ns/1ps
`include "trigger_sequencer_map.vh"
module trigger_sequencer_param_regs_test;
    // ----
    // Stimulus and observation signals.
    // ----
    reg         clk_sys_i = 1'b0;
    reg         srst_i = 1'b1;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid, chsel_wr;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] chsel;
    integer     n_mismatch = 0, n_checks = 0, seed = 31, i;
    reg  [15:0] exp_r [0:16];   // Expected contents: parameters 0..7, pointer 8, queue words 9..16.
    reg  [31:0] rd;             // Last read data.
    reg  [1:0]  rsp;            // Last response code.
    reg  [15:0] chsel_q [$];    // Channel-select values seen, in order.
    trigger_sequencer_param_regs u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .adc_chsel_o(chsel), .adc_chsel_wr_o(chsel_wr));
    // ----
    // Clock, channel-select monitor and helpers.
    // ----
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (chsel_wr) chsel_q.push_back(chsel);
    // Byte address of register slot k.
    function [7:0] addr_of(input integer k);
        addr_of = 8'((k < 9) ? `TSQ_ADDR_TIMER0_LIM + 4 * k : `TSQ_ADDR_QUEUE_BASE + 4 * (k - 9));
    endfunction
    // Compares and counts; a mismatch is reported at once.
    task check(input [33:0] got, input [33:0] want);
        begin
            n_checks = n_checks + 1;
            if (got !== want) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0t got %h want %h", $time, got, want);
            end
        end
    endtask
    // Write with address and data offered together; each is released once taken.
    task axi_write(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys_i);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge clk_sys_i);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            rsp = bresp;
            bready <= 1'b0;
        end
    endtask
    // Read one word; data and response are taken at the edge where rvalid is seen.
    task axi_read(input [7:0] a);
        begin
            @(posedge clk_sys_i);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge clk_sys_i);
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            rd = rdata;
            rsp = rresp;
            rready <= 1'b0;
        end
    endtask
    task stop_test;
        begin
            if (n_mismatch == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // Watchdog: far beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
    // ----
    // Main sequence.
    // ----
    initial begin
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (i = 0; i < 17; i = i + 1) begin
            axi_read(addr_of(i));
            check({rsp, rd}, 34'h0);
        end
        // Random values, upper bits included, must read back masked.
        for (i = 0; i < 17; i = i + 1) begin
            rd = $random(seed);
            axi_write(addr_of(i), rd);
            exp_r[i] = rd[15:0] & ((i == 8) ? 16'h001F : 16'hFFFF);
        end
        for (i = 0; i < 17; i = i + 1) begin
            axi_read(addr_of(i));
            check(rd, {18'h0, exp_r[i]});
        end
        axi_write(`TSQ_ADDR_QUEUE_PTR, 32'hFFFFFFFF);
        axi_read(`TSQ_ADDR_QUEUE_PTR);
        check(rd, 34'h1F);
        axi_write(8'h30, 32'h1234);
        check(rsp, `TSQ_RESP_SLVERR);
        axi_read(8'h30);
        check({rsp, rd}, {`TSQ_RESP_SLVERR, 32'h0});
        // Queue: literal out, copy hold to literal, add adjust, literal out; rest no-ops.
        exp_r[8] = 16'h0000;
        exp_r[9] = 16'h1D0E;
        exp_r[10] = 16'h0E15;
        for (i = 11; i < 17; i = i + 1) exp_r[i] = 16'h0000;
        for (i = 8; i < 17; i = i + 1) axi_write(addr_of(i), {16'h0, exp_r[i]});
        chsel_q.delete();
        axi_write(`TSQ_ADDR_CONTROL, 32'h3);
        for (i = 0; i < 17; i = i + 1) if (i < 7 || i > 8) axi_write(addr_of(i), ~exp_r[i]);
        for (i = 0; i < 17; i = i + 1) begin
            if (i < 7 || i > 8) axi_read(addr_of(i));
            if (i < 7 || i > 8) check(rd, {18'h0, exp_r[i]});
        end
        while (chsel_q.size() < 2) @(posedge clk_sys_i);
        check(chsel_q[0], exp_r[7]);
        check(chsel_q[1], 16'(exp_r[5] + exp_r[6]));
        axi_write(`TSQ_ADDR_CONTROL, 32'h1);
        axi_read(`TSQ_ADDR_QUEUE_PTR);
        exp_r[8] = rd[15:0];
        repeat (3) @(posedge clk_sys_i);
        axi_read(`TSQ_ADDR_QUEUE_PTR);
        check(rd, {18'h0, exp_r[8]});
        axi_write(addr_of(0), 32'hA5A5);
        axi_read(addr_of(0));
        check(rd, 34'hA5A5);
        // A reset in mid-run clears parameters but keeps the queue.
        axi_write(`TSQ_ADDR_CONTROL, 32'h3);
        srst_i <= 1'b1;
        @(posedge clk_sys_i);
        srst_i <= 1'b0;
        axi_read(addr_of(9));
        check(rd, 34'h1D0E);
        axi_read(addr_of(0));
        check(rd, 34'h0);
        stop_test;
    end
endmodule
